// ### src/rtcs_pkg.sv
package rtcs_pkg;
  // Fixed write form of the slave address byte
  localparam logic [7:0] SLAVE_ADDR = 8'hD0;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h0E;
  localparam logic [7:0] STAT_OFS = 8'h0F;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h18;
  localparam logic [7:0] STAT_RST = 8'hA0;
  // Reference rate select codes
  localparam logic [1:0] REF_RATE_1HZ = 2'h0;
  localparam logic [1:0] REF_RATE_50HZ = 2'h1;
  localparam logic [1:0] REF_RATE_60HZ = 2'h2;
  localparam logic [1:0] REF_RATE_32K = 2'h3;
  // Bit counts within one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;

  // Control register layout
  typedef struct packed {
    logic osc_disable_ctl;
    logic spare;
    logic glitch_filter_en;
    logic [1:0] square_rate;
    logic irq_steer_select;
    logic alarm_two_irq_enable;
    logic alarm_one_irq_enable;
  } rtcs_ctrl_s;

  // Status and reference select register layout
  typedef struct packed {
    logic osc_halt_flag;
    logic osc_halt_detect_disable;
    logic ref_clock_missing;
    logic ref_rate_select_hi;
    logic ref_rate_select_lo;
    logic ext_ref_input_enable;
    logic alarm_two_flag;
    logic alarm_one_flag;
  } rtcs_stat_s;

  // Register write passed from the bus side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rtcs_wr_s;

  // Byte-level state of the serial slave
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA} rtcs_i2c_e;
endpackage

// ### src/rtcs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: Steer 0, pin output: either enabled alarm
// R02: Steer 1, pin output: alarm one only
// R03: Steer 0 alarm two pulls pin A
// R04: Steer 1 alarm two pulls pin B
// R05: Alarm one match sets its flag
// R06: Alarm flags clear only on written 0
// R07: Halt flag sets on run-to-stop edge
// R08: Halt flag holds until written 0
// R09: Halt flag is 1 after power-up
// R10: Detect disable keeps halt flag 0
// R11: Reference loss flag set when not conditioned
// R12: Loss flag sticky, power-up value 1
// R13: Clearing while invalid inhibits deviation detection
// R14: Two-bit rate select, resets to 00
// R15: Reference enable makes pin A input
// R16: Answer only address D0h, LSB direction
// R17: Detect start and stop conditions
// R18: Repeated start handled like start
// R19: Sample incoming bits on SCL rise
// R20: Drive read bits after SCL fall
// R21: Master makes all SCL pulses
// R22: Ninth bit acknowledge, not-ack ends read
// R23: Bytes most significant first, slave acks
// R24: Steer 0 puts square wave on B
// R25: Steer 1 with reference: B on either
// R26: Interrupt pins active low, open drain
module rtcs_ctrl (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // Two-wire bus, SCL is the link clock
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  // Events and status from neighbouring logic
  input wire logic ALARM_ONE_MATCH_I,
  input wire logic ALARM_TWO_MATCH_I,
  input wire logic OSC_RUNNING_I,
  input wire logic REF_TOGGLING_I,
  input wire logic REF_FREQ_OK_I,
  input wire logic SQUARE_WAVE_OUT_I,
  // Shared reference input or interrupt A pin
  input wire logic REFCLK_OR_IRQ_A_PIN_I,
  output logic REFCLK_OR_IRQ_A_PIN_O,
  output logic REFCLK_OR_IRQ_A_PIN_OE_N_O,
  // Square wave or interrupt B pin
  output logic SQUARE_OR_IRQ_B_PIN_O,
  output logic SQUARE_OR_IRQ_B_PIN_OE_N_O,
  // Control fields to neighbouring logic
  output logic REF_IN_O,
  output logic OSC_DISABLE_CTL_O,
  output logic GLITCH_FILTER_EN_O,
  output logic [1:0] SQUARE_RATE_O,
  output logic [1:0] REF_RATE_SELECT_O
);

  // Bus pin synchronisers and history
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  // Start and stop strobes, bus activity
  logic start_det, stop_det, bus_busy;
  // Start event toggle towards the link side
  logic st_tog;
  // Write event toggle synchroniser
  logic wt_s1, wt_s2, wt_s3;
  // Drive request synchroniser
  logic drv_s1, drv_s2;
  // Oscillator run synchroniser
  logic osc_s1, osc_s2, osc_s3;
  // Reference pin synchroniser
  logic ref_s1, ref_s2;
  // Registers
  rtcs_pkg::rtcs_ctrl_s ctrl;
  rtcs_pkg::rtcs_stat_s stat;
  // Write decode
  logic wr_now, wr_ctrl, wr_stat;
  rtcs_pkg::rtcs_stat_s wd;
  // Oscillator disable history
  logic osc_disable_ctl_q;
  // Deviation detection inhibit
  logic dev_inhibit;
  // Flag conditions
  logic osc_stop, los_cond, a1q, a2q;
  // Read data held for the link side
  logic [7:0] rd_hold;

  // Link side state
  logic rs1, rst_scl;
  logic [7:0] sh;
  logic st_a, st_b, st_c;
  rtcs_pkg::rtcs_i2c_e state;
  logic [3:0] cnt, next_cnt;
  logic rw;
  logic sda_drv;
  logic [7:0] ptr;
  logic [7:0] obyte;
  logic wr_tog;
  rtcs_pkg::rtcs_wr_s wr_req;

  // Two flops on each bus pin, then one history stage
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= SCL_I;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // Data edges while the clock stays high
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2; // R17 R18
  assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2; // R17

  // Bus activity and start event toggle
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      bus_busy <= 1'b0;
      st_tog <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
      st_tog <= ~st_tog; // R18
    end else if (stop_det) begin
      bus_busy <= 1'b0; // R17
    end
  end

  // Other level synchronisers and histories
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wt_s1 <= 1'b0;
      wt_s2 <= 1'b0;
      wt_s3 <= 1'b0;
      drv_s1 <= 1'b0;
      drv_s2 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      osc_disable_ctl_q <= 1'b0;
    end else begin
      wt_s1 <= wr_tog;
      wt_s2 <= wt_s1;
      wt_s3 <= wt_s2;
      drv_s1 <= sda_drv;
      drv_s2 <= drv_s1;
      osc_s1 <= OSC_RUNNING_I;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      ref_s1 <= REFCLK_OR_IRQ_A_PIN_I;
      ref_s2 <= ref_s1;
      osc_disable_ctl_q <= ctrl.osc_disable_ctl;
    end
  end

  // Write strobe; address and data stay still for a whole byte
  assign wr_now = wt_s2 ^ wt_s3;
  assign wr_ctrl = wr_now & (wr_req.addr == rtcs_pkg::CTRL_OFS);
  assign wr_stat = wr_now & (wr_req.addr == rtcs_pkg::STAT_OFS);
  assign wd = rtcs_pkg::rtcs_stat_s'(wr_req.data);

  // Flag causes
  assign osc_stop = osc_s3 & ~osc_s2; // R07
  assign los_cond = ~stat.ext_ref_input_enable | ~REF_TOGGLING_I
                    | (~REF_FREQ_OK_I & ~dev_inhibit); // R11 R13
  assign a1q = stat.alarm_one_flag & ctrl.alarm_one_irq_enable;
  assign a2q = stat.alarm_two_flag & ctrl.alarm_two_irq_enable;

  // Control register, spare bit reads zero
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl <= rtcs_pkg::rtcs_ctrl_s'(rtcs_pkg::CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl <= rtcs_pkg::rtcs_ctrl_s'(wr_req.data);
      ctrl.spare <= 1'b0;
    end
  end

  // Plain fields of the status register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      stat.osc_halt_detect_disable <= 1'b0; // R10
      stat.ref_rate_select_hi <= 1'b0; // R14
      stat.ref_rate_select_lo <= 1'b0; // R14
      stat.ext_ref_input_enable <= 1'b0; // R15
    end else if (wr_stat) begin
      stat.osc_halt_detect_disable <= wd.osc_halt_detect_disable;
      stat.ref_rate_select_hi <= wd.ref_rate_select_hi;
      stat.ref_rate_select_lo <= wd.ref_rate_select_lo;
      stat.ext_ref_input_enable <= wd.ext_ref_input_enable;
    end
  end

  // Oscillator halt flag; a set beats a clear in the same cycle
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      stat.osc_halt_flag <= 1'b1; // R09
    end else if (stat.osc_halt_detect_disable) begin
      stat.osc_halt_flag <= 1'b0; // R10
    end else if (osc_stop | (ctrl.osc_disable_ctl & ~osc_disable_ctl_q)) begin
      stat.osc_halt_flag <= 1'b1; // R07 R09
    end else if (wr_stat & ~wd.osc_halt_flag) begin
      stat.osc_halt_flag <= 1'b0; // R08
    end
  end

  // Reference loss flag, sticky while its cause persists
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      stat.ref_clock_missing <= 1'b1; // R12
    end else if (los_cond) begin
      stat.ref_clock_missing <= 1'b1; // R11
    end else if (wr_stat & ~wd.ref_clock_missing) begin
      stat.ref_clock_missing <= 1'b0; // R12
    end
  end

  // Inhibit set by clearing loss during a bad rate, dropped with enable
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      dev_inhibit <= 1'b0;
    end else if (~stat.ext_ref_input_enable) begin
      dev_inhibit <= 1'b0;
    end else if (wr_stat & ~wd.ref_clock_missing & ~REF_FREQ_OK_I) begin
      dev_inhibit <= 1'b1; // R13
    end
  end

  // Alarm flags; match beats a clear, writing 1 changes nothing
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      stat.alarm_one_flag <= 1'b0;
      stat.alarm_two_flag <= 1'b0;
    end else begin
      if (ALARM_ONE_MATCH_I) begin
        stat.alarm_one_flag <= 1'b1; // R05
      end else if (wr_stat & ~wd.alarm_one_flag) begin
        stat.alarm_one_flag <= 1'b0; // R06
      end
      if (ALARM_TWO_MATCH_I) begin
        stat.alarm_two_flag <= 1'b1;
      end else if (wr_stat & ~wd.alarm_two_flag) begin
        stat.alarm_two_flag <= 1'b0; // R06
      end
    end
  end

  // Pin routing, open drain: enable low pulls the pin low
  always_ff @(posedge CLK_I) begin // R26
    if (SRST_I) begin
      REFCLK_OR_IRQ_A_PIN_O <= 1'b0;
      REFCLK_OR_IRQ_A_PIN_OE_N_O <= 1'b1;
      SQUARE_OR_IRQ_B_PIN_O <= 1'b0;
      SQUARE_OR_IRQ_B_PIN_OE_N_O <= 1'b1;
      REF_IN_O <= 1'b0;
    end else begin
      REFCLK_OR_IRQ_A_PIN_O <= 1'b0;
      SQUARE_OR_IRQ_B_PIN_O <= 1'b0;
      REF_IN_O <= stat.ext_ref_input_enable & ref_s2; // R15
      if (stat.ext_ref_input_enable) begin
        REFCLK_OR_IRQ_A_PIN_OE_N_O <= 1'b1; // R15
      end else if (ctrl.irq_steer_select) begin
        REFCLK_OR_IRQ_A_PIN_OE_N_O <= ~a1q; // R02 R05
      end else begin
        REFCLK_OR_IRQ_A_PIN_OE_N_O <= ~(a1q | a2q); // R01 R03 R05
      end
      if (~ctrl.irq_steer_select) begin
        SQUARE_OR_IRQ_B_PIN_OE_N_O <= SQUARE_WAVE_OUT_I; // R24
      end else if (stat.ext_ref_input_enable) begin
        SQUARE_OR_IRQ_B_PIN_OE_N_O <= ~(a1q | a2q); // R25
      end else begin
        SQUARE_OR_IRQ_B_PIN_OE_N_O <= ~a2q; // R04
      end
    end
  end

  // Data line driver; released at stop and outside a transfer
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      SDA_O <= 1'b0;
      SDA_OE_N_O <= 1'b1;
    end else begin
      SDA_O <= 1'b0;
      SDA_OE_N_O <= ~(drv_s2 & bus_busy & ~stop_det); // R17
    end
  end

  // Read data follows the pointer only while the bus clock is low
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rd_hold <= 8'h00;
    end else if (~scl_s2 & ~scl_s3) begin
      if (ptr == rtcs_pkg::CTRL_OFS) begin
        rd_hold <= ctrl;
      end else if (ptr == rtcs_pkg::STAT_OFS) begin
        rd_hold <= stat;
      end else begin
        rd_hold <= 8'h00;
      end
    end
  end

  // Control fields out
  assign OSC_DISABLE_CTL_O = ctrl.osc_disable_ctl;
  assign GLITCH_FILTER_EN_O = ctrl.glitch_filter_en;
  assign SQUARE_RATE_O = ctrl.square_rate;
  assign REF_RATE_SELECT_O = {stat.ref_rate_select_hi, stat.ref_rate_select_lo}; // R14

  // Reset into the link domain, takes effect once SCL runs
  always_ff @(posedge SCL_I) begin
    rs1 <= SRST_I;
    rst_scl <= rs1;
  end

  // Rising edge: shift in data, carry start toggle second stage
  always_ff @(posedge SCL_I) begin
    if (rst_scl) begin
      sh <= 8'h00;
      st_b <= 1'b0;
    end else begin
      sh <= {sh[6:0], SDA_I}; // R19 R23
      st_b <= st_a;
    end
  end

  assign next_cnt = cnt + 4'h1;

  // Falling edge: byte sequencing and outgoing bits
  always_ff @(negedge SCL_I) begin
    st_a <= st_tog;
    if (rst_scl) begin
      st_c <= 1'b0;
      state <= rtcs_pkg::ST_IDLE;
      cnt <= 4'h0;
      rw <= 1'b0;
      sda_drv <= 1'b0;
      ptr <= 8'h00;
      obyte <= 8'h00;
      wr_tog <= 1'b0;
      wr_req <= '0;
    end else begin
      st_c <= st_b;
      if (st_b != st_c) begin
        // One bit of the address byte is already in
        state <= rtcs_pkg::ST_ADDR; // R18
        cnt <= 4'h1;
        sda_drv <= 1'b0;
      end else if (state != rtcs_pkg::ST_IDLE) begin
        cnt <= next_cnt;
        if (next_cnt == rtcs_pkg::BYTE_BITS) begin
          // Whole byte received or sent
          unique case (state)
            rtcs_pkg::ST_ADDR: begin
              if (sh[7:1] == rtcs_pkg::SLAVE_ADDR[7:1]) begin
                rw <= sh[0]; // R16
                sda_drv <= 1'b1; // R22 R23
              end else begin
                state <= rtcs_pkg::ST_IDLE; // R16
              end
            end
            rtcs_pkg::ST_PTR: begin
              ptr <= sh;
              sda_drv <= 1'b1; // R23
            end
            rtcs_pkg::ST_WDATA: begin
              wr_req <= '{addr: ptr, data: sh};
              wr_tog <= ~wr_tog;
              ptr <= ptr + 8'h01;
              sda_drv <= 1'b1; // R23
            end
            rtcs_pkg::ST_RDATA: begin
              sda_drv <= 1'b0;
              ptr <= ptr + 8'h01;
            end
            rtcs_pkg::ST_IDLE: begin
              sda_drv <= 1'b0;
            end
          endcase
        end else if (next_cnt == rtcs_pkg::ACK_BIT) begin
          // Ninth bit done
          cnt <= 4'h0;
          sda_drv <= 1'b0;
          unique case (state)
            rtcs_pkg::ST_ADDR: begin
              if (rw) begin
                state <= rtcs_pkg::ST_RDATA;
                obyte <= {rd_hold[6:0], 1'b0};
                sda_drv <= ~rd_hold[7]; // R20
              end else begin
                state <= rtcs_pkg::ST_PTR;
              end
            end
            rtcs_pkg::ST_PTR: begin
              state <= rtcs_pkg::ST_WDATA;
            end
            rtcs_pkg::ST_RDATA: begin
              if (~sh[0]) begin
                obyte <= {rd_hold[6:0], 1'b0}; // R22
                sda_drv <= ~rd_hold[7];
              end else begin
                state <= rtcs_pkg::ST_IDLE; // R22
              end
            end
            rtcs_pkg::ST_WDATA, rtcs_pkg::ST_IDLE: begin
              sda_drv <= 1'b0;
            end
          endcase
        end else if (state == rtcs_pkg::ST_RDATA) begin
          // Next bit after the falling edge, master clocks it
          sda_drv <= ~obyte[7]; // R20 R21
          obyte <= {obyte[6:0], 1'b0};
        end
      end
    end
  end

  // Checks beside the logic
  a_inta_any: assert property (@(posedge CLK_I) disable iff (SRST_I) // R01
    (!stat.ext_ref_input_enable && !ctrl.irq_steer_select && (a1q || a2q))
    |=> !REFCLK_OR_IRQ_A_PIN_OE_N_O)
    else $error("pin A not pulled for enabled alarm");
  a_inta_one: assert property (@(posedge CLK_I) disable iff (SRST_I) // R02
    (!stat.ext_ref_input_enable && ctrl.irq_steer_select && !a1q)
    |=> REFCLK_OR_IRQ_A_PIN_OE_N_O)
    else $error("pin A pulled without alarm one");
  a_intb_two: assert property (@(posedge CLK_I) disable iff (SRST_I) // R04
    (ctrl.irq_steer_select && !stat.ext_ref_input_enable && a2q)
    |=> !SQUARE_OR_IRQ_B_PIN_OE_N_O)
    else $error("pin B not pulled for alarm two");
  a_intb_wave: assert property (@(posedge CLK_I) disable iff (SRST_I) // R24
    !ctrl.irq_steer_select |=> SQUARE_OR_IRQ_B_PIN_OE_N_O == $past(SQUARE_WAVE_OUT_I))
    else $error("pin B not following square wave");
  a_intb_both: assert property (@(posedge CLK_I) disable iff (SRST_I) // R25
    (ctrl.irq_steer_select && stat.ext_ref_input_enable && (a1q || a2q))
    |=> !SQUARE_OR_IRQ_B_PIN_OE_N_O)
    else $error("pin B not pulled for either alarm");
  a_alarm_set: assert property (@(posedge CLK_I) disable iff (SRST_I) // R05
    ALARM_ONE_MATCH_I |=> stat.alarm_one_flag)
    else $error("alarm one flag missed match");
  a_flag_keep: assert property (@(posedge CLK_I) disable iff (SRST_I) // R06
    (stat.alarm_two_flag && !(wr_stat && !wd.alarm_two_flag)) |=> stat.alarm_two_flag)
    else $error("alarm two flag lost");
  a_halt_sense: assert property (@(posedge CLK_I) disable iff (SRST_I) // R07
    (osc_stop && !stat.osc_halt_detect_disable) |=> stat.osc_halt_flag)
    else $error("halt flag missed stop edge");
  a_halt_off: assert property (@(posedge CLK_I) disable iff (SRST_I) // R10
    stat.osc_halt_detect_disable |=> !stat.osc_halt_flag)
    else $error("halt flag set while disabled");
  a_power_vals: assert property (@(posedge CLK_I) disable iff (SRST_I) // R09
    $fell(SRST_I) |-> (stat.osc_halt_flag && stat.ref_clock_missing
    && REF_RATE_SELECT_O == rtcs_pkg::REF_RATE_1HZ))
    else $error("wrong status after reset");
  a_ref_loss: assert property (@(posedge CLK_I) disable iff (SRST_I) // R11
    !stat.ext_ref_input_enable |=> stat.ref_clock_missing)
    else $error("loss flag clear without reference");
  a_ref_input: assert property (@(posedge CLK_I) disable iff (SRST_I) // R15
    stat.ext_ref_input_enable |=> REFCLK_OR_IRQ_A_PIN_OE_N_O)
    else $error("pin A driven while an input");
  a_stop_free: assert property (@(posedge CLK_I) disable iff (SRST_I) // R17
    stop_det |=> SDA_OE_N_O ##1 SDA_OE_N_O)
    else $error("data line held after stop");
  a_addr_miss: assert property (@(negedge SCL_I) disable iff (rst_scl) // R16
    (st_b == st_c && state == rtcs_pkg::ST_ADDR && next_cnt == rtcs_pkg::BYTE_BITS
    && sh[7:1] != rtcs_pkg::SLAVE_ADDR[7:1]) |=> state == rtcs_pkg::ST_IDLE && !sda_drv)
    else $error("foreign address acknowledged");

endmodule // rtcs_ctrl
`default_nettype wire

// ### verification/rtcs_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// Two-wire bus master, SDA released to the pull-up
module rtcs_i2c_master (
  // Data line level as seen on the wire
  input wire logic sda_i,
  // Clock line, and data pull-down enable (low while pulling)
  output logic scl_o,
  output logic sda_oe_n_o
);
  // Quarter of the 125 ns link period
  localparam realtime QT = 31.25;
  // Idle bus: both lines high
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // One bit slot; data moves only in the SCL low phase, sampled at the rise
  task automatic bit_io(input logic b, output logic r);
    #QT sda_oe_n_o = b;
    #QT scl_o = 1'b1;
    r = sda_i;
    #(2 * QT) scl_o = 1'b0;
  endtask
  // START or repeated START; SCL left low
  task automatic start_c();
    #QT sda_oe_n_o = 1'b1;
    #QT scl_o = 1'b1;
    #QT sda_oe_n_o = 1'b0;
    #QT scl_o = 1'b0;
  endtask
  // STOP; SCL then stands high
  task automatic stop_c();
    #QT sda_oe_n_o = 1'b0;
    #QT scl_o = 1'b1;
    #QT sda_oe_n_o = 1'b1;
    #QT;
  endtask
  // Byte to the slave, most significant first; returns its ninth bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, ack);
  endtask
  // Byte from the slave; master answers ACK (0) or NACK (1)
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule // rtcs_i2c_master
`default_nettype wire

// ### verification/rtc_status_irq_route_i2c_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_status_irq_route_i2c_port_tb_top;
  // Clock, reset and neighbour inputs
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic a1m = 1'b0;
  logic a2m = 1'b0;
  logic osc_run = 1'b1;
  logic ref_tog = 1'b1;
  logic ref_ok = 1'b1;
  logic sq = 1'b1;
  logic ref_drv = 1'b1;
  // Wires and design outputs
  logic scl, m_oe_n, sda, sda_out, sda_oe_n, pin_a, a_out, a_oe_n, b_out, b_oe_n;
  logic ref_in, osc_dis, gf, k, ea, eb;
  logic [1:0] sq_rate, rate_sel;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // Open-drain lines with pull-ups; pin A carries the reference when released
  assign sda = m_oe_n & sda_oe_n;
  assign pin_a = a_oe_n ? ref_drv : 1'b0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Design under test
  rtcs_ctrl rtcs_ctrl_inst (
    .CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out),
    .SDA_OE_N_O(sda_oe_n), .ALARM_ONE_MATCH_I(a1m), .ALARM_TWO_MATCH_I(a2m),
    .OSC_RUNNING_I(osc_run), .REF_TOGGLING_I(ref_tog), .REF_FREQ_OK_I(ref_ok),
    .SQUARE_WAVE_OUT_I(sq), .REFCLK_OR_IRQ_A_PIN_I(pin_a), .REFCLK_OR_IRQ_A_PIN_O(a_out),
    .REFCLK_OR_IRQ_A_PIN_OE_N_O(a_oe_n), .SQUARE_OR_IRQ_B_PIN_O(b_out),
    .SQUARE_OR_IRQ_B_PIN_OE_N_O(b_oe_n), .REF_IN_O(ref_in), .OSC_DISABLE_CTL_O(osc_dis),
    .GLITCH_FILTER_EN_O(gf), .SQUARE_RATE_O(sq_rate), .REF_RATE_SELECT_O(rate_sel)
  );
  // Bus master partner
  rtcs_i2c_master rtcs_i2c_master_inst (.sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
  // Byte comparison
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // Counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Register write: address, pointer, data; every byte must be acknowledged
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    rtcs_i2c_master_inst.start_c();
    rtcs_i2c_master_inst.put_byte(rtcs_pkg::SLAVE_ADDR, k0);
    rtcs_i2c_master_inst.put_byte(a, k1);
    rtcs_i2c_master_inst.put_byte(d, k2);
    rtcs_i2c_master_inst.stop_c();
    chk8({5'h00, k0, k1, k2}, 8'h00, "write acks");
    @(negedge clk);
  endtask
  // Pointer, repeated START, two reads, masked compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e0,
                       input logic [7:0] e1);
    logic [7:0] d0, d1;
    logic k0, k1, k2;
    rtcs_i2c_master_inst.start_c();
    rtcs_i2c_master_inst.put_byte(rtcs_pkg::SLAVE_ADDR, k0);
    rtcs_i2c_master_inst.put_byte(a, k1);
    rtcs_i2c_master_inst.start_c();
    rtcs_i2c_master_inst.put_byte(rtcs_pkg::SLAVE_ADDR | 8'h01, k2);
    rtcs_i2c_master_inst.get_byte(1'b0, d0);
    rtcs_i2c_master_inst.get_byte(1'b1, d1);
    rtcs_i2c_master_inst.stop_c();
    chk8({5'h00, k0, k1, k2}, 8'h00, "read acks");
    chk8(d0 & m, e0, "first byte");
    chk8(d1 & m, e1, "second byte");
    @(negedge clk);
  endtask
  // One-cycle match pulse on alarm one (w=0) or alarm two (w=1)
  task automatic pulse(input logic w);
    @(negedge clk);
    a1m = !w;
    a2m = w;
    @(negedge clk);
    a1m = 1'b0;
    a2m = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      complete_run();
    end
  end
  // Test sequence
  initial begin
    repeat (6) @(negedge clk);
    // Idle SCL pulses carry reset into the link side and out again
    repeat (4) rtcs_i2c_master_inst.bit_io(1'b1, k);
    @(negedge clk);
    srst = 1'b0;
    repeat (2) rtcs_i2c_master_inst.bit_io(1'b1, k);
    repeat (6) @(negedge clk);
    chk8({6'h00, a_oe_n, b_oe_n}, 8'h03, "pins after reset");
    rdchk(rtcs_pkg::CTRL_OFS, 8'hFF, rtcs_pkg::CTRL_RST, rtcs_pkg::STAT_RST);
    $display("reset values done");
    // Sticky flags: loss stays while the reference is off, ones do nothing
    wr(rtcs_pkg::STAT_OFS, 8'h00);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h20, 8'h00);
    wr(rtcs_pkg::STAT_OFS, 8'h83);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h20, 8'h00);
    // Foreign address is not acknowledged
    rtcs_i2c_master_inst.start_c();
    rtcs_i2c_master_inst.put_byte(8'hD2, k);
    rtcs_i2c_master_inst.stop_c();
    chk8({7'h00, k}, 8'h01, "foreign address");
    $display("sticky flags done");
    // Oscillator stop sets the halt flag unless detection is off
    osc_run = 1'b0;
    repeat (8) @(negedge clk);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'hA0, 8'h00);
    osc_run = 1'b1;
    wr(rtcs_pkg::STAT_OFS, 8'h40);
    osc_run = 1'b0;
    repeat (8) @(negedge clk);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h60, 8'h00);
    osc_run = 1'b1;
    wr(rtcs_pkg::STAT_OFS, 8'h00);
    $display("halt flag done");
    // Reference loss, deviation inhibit; a clear loses to a same-cycle set
    repeat (2) wr(rtcs_pkg::STAT_OFS, 8'h04);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h04, 8'h00);
    ref_ok = 1'b0;
    repeat (8) @(negedge clk);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h24, 8'h00);
    repeat (2) wr(rtcs_pkg::STAT_OFS, 8'h04);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h04, 8'h00);
    ref_tog = 1'b0;
    repeat (8) @(negedge clk);
    rdchk(rtcs_pkg::STAT_OFS, 8'hFF, 8'h24, 8'h00);
    ref_tog = 1'b1;
    ref_ok = 1'b1;
    ref_drv = 1'b0;
    repeat (6) @(negedge clk);
    chk8({7'h00, ref_in}, 8'h00, "reference low");
    ref_drv = 1'b1;
    repeat (6) @(negedge clk);
    chk8({7'h00, ref_in}, 8'h01, "reference high");
    $display("reference loss done");
    // Every rate code reaches the select output
    for (int r = 0; r < 4; r++) begin
      wr(rtcs_pkg::STAT_OFS, 8'hA7 | (8'(r) << 3));
      chk8({6'h00, rate_sel}, 8'(r), "rate select");
    end
    $display("rate select done");
    // Routing table over steer, reference enable and each alarm
    for (int c = 0; c < 4; c++) begin
      for (int w = 0; w < 2; w++) begin
        wr(rtcs_pkg::CTRL_OFS, 8'h1B | (c[1] ? 8'h04 : 8'h00));
        wr(rtcs_pkg::STAT_OFS, 8'hA0 | (c[0] ? 8'h04 : 8'h00));
        pulse(w[0]);
        ea = c[0] | (c[1] & w[0]);
        eb = c[1] ? !(c[0] | w[0]) : sq;
        chk8({7'h00, a_oe_n}, {7'h00, ea}, "pin A");
        chk8({7'h00, b_oe_n}, {7'h00, eb}, "pin B");
        rdchk(rtcs_pkg::STAT_OFS, 8'h03, w[0] ? 8'h02 : 8'h01, 8'h00);
      end
    end
    // Ones keep the flag; disabled alarm releases pin A; B follows the square wave
    wr(rtcs_pkg::STAT_OFS, 8'hA3);
    rdchk(rtcs_pkg::STAT_OFS, 8'h07, 8'h02, 8'h00);
    wr(rtcs_pkg::CTRL_OFS, 8'h18);
    sq = 1'b0;
    repeat (4) @(negedge clk);
    chk8({6'h00, a_oe_n, b_oe_n}, 8'h02, "pins disabled");
    $display("routing done");
    complete_run();
  end
endmodule // rtc_status_irq_route_i2c_port_tb_top
`default_nettype wire
